// *** verilog/dmau_defines.svh ***
`ifndef DMAU_DEFINES_SVH
`define DMAU_DEFINES_SVH

// =====================================================
// data space map of block-held registers
`define BANK_ADDR 12'hFE0
`define STATUS_ADDR 12'hFD8
`define WORK_ADDR 12'hFE8
`define PTR_LOW_BASE 12'hFE9
`define OPER_BASE 12'hFEB
`define PTR_STRIDE 12'h008
`define OPER_COUNT 12'h005
`define PTR_COUNT 3
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0
`define IMPL_BANKS 16'h803F

// =====================================================
// status flag positions
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define FLAG_BITS 5
`define NULL_READ 8'h00

// =====================================================
// bus byte offsets
`define BUS_BANK 6'h00
`define BUS_STATUS 6'h04
`define BUS_WORK 6'h08
`define BUS_PTR_BASE 6'h0C
`define BUS_LAST 6'h24
`define RESET_PTR 12'h000
`define RESET_BANK 4'h0
`define RESET_WORK 8'h00
`endif

// *** verilog/dmau_pkg.sv ***
package dmau_pkg;
	// access sequencing
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01,
		ST_DATA = 2'b10,
		ST_DONE = 2'b11
	} state_t;
	// pointer operand modes, by offset from operand base
	typedef enum logic [2:0] {
		MODE_PLUS_WORK = 3'b000,
		MODE_PRE_INC = 3'b001,
		MODE_POST_INC = 3'b010,
		MODE_POST_DEC = 3'b011,
		MODE_PLAIN = 3'b100
	} ptr_mode_t;
	// where a resolved address lands
	typedef enum logic [1:0] {
		TK_RAM = 2'b00,
		TK_REG = 2'b01,
		TK_VOID = 2'b10,
		TK_NULL = 2'b11
	} target_kind_t;
endpackage

// *** verilog/file_pointer_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmau_defines.svh"
module file_pointer_unit (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// byte loads
	input wire logic load_low,
	input wire logic load_high,
	input wire logic [7:0] load_data,
	// stepping
	input wire logic step_up,
	input wire logic step_down,
	// pointer value
	output logic [11:0] ptr
);
	// =====================================================
	// pointer register
	// a load wins over a step in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ptr <= `RESET_PTR;
		end else if (load_low || load_high) begin
			if (load_low) begin
				ptr[7:0] <= load_data;
			end
			if (load_high) begin
				ptr[11:8] <= load_data[3:0];
			end
		end else if (step_up) begin
			ptr <= ptr + 12'h001;
		end else if (step_down) begin
			ptr <= ptr - 12'h001;
		end
	end
endmodule // file_pointer_unit
`default_nettype wire

// *** verilog/data_memory_address_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmau_defines.svh"
module data_memory_address_unit
	import dmau_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// core access request
	input wire logic req_valid,
	input wire logic req_move_file_to_file,
	input wire logic req_access,
	input wire logic [7:0] req_file,
	input wire logic [11:0] req_full_addr,
	input wire logic req_write,
	input wire logic [7:0] req_wdata,
	input wire logic [4:0] req_flag_mask,
	input wire logic [4:0] req_flag_val,
	output logic req_ready,
	// core response
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	// data ram
	output logic [11:0] ram_addr,
	output logic ram_re,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata,
	// register state seen by alu
	output logic [4:0] status_flags,
	output logic [7:0] working_register,
	// avalon register slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	// =====================================================
	// declarations
	state_t state_r; // access sequencer
	target_kind_t kind; // class of resolved address
	target_kind_t kind_r; // class held for response
	ptr_mode_t mode; // operand mode decoded
	logic [3:0] bank_select_r; // low nibble only is kept
	logic [11:0] ptr_val [`PTR_COUNT]; // pointer values
	logic [2:0] load_low; // per-pointer low byte load
	logic [2:0] load_high; // per-pointer high byte load
	logic [2:0] step_up; // per-pointer increment
	logic [2:0] step_down; // per-pointer decrement
	logic [7:0] load_data; // shared load data
	logic [11:0] eff_addr; // operand address
	logic [11:0] tgt; // final data address
	logic [11:0] ptr_sel; // pointer picked by operand
	logic [11:0] last_tgt_r; // last resolved address
	logic [5:0] od; // operand decode of eff_addr
	logic [8:0] reg_hit; // block register read of tgt
	logic [7:0] hold_r; // read value for non-ram targets
	logic is_ind; // operand is a pointer location
	logic take; // request taken this edge
	logic bus_go; // bus request answered this edge
	logic bus_wr; // bus write with low lane
	logic core_reg_wr; // core write to block register
	logic [7:0] bus_rd; // bus read value

	// =====================================================
	// operand location decode
	// returns hit, pointer number and mode offset
	function automatic logic [5:0] oper_decode(input logic [11:0] a);
		logic [11:0] base;
		logic [11:0] diff;
		oper_decode = 6'h00;
		for (int i = 0; i < `PTR_COUNT; i++) begin
			base = `OPER_BASE - 12'(`PTR_STRIDE * i);
			diff = a - base;
			if (diff < `OPER_COUNT) begin
				oper_decode = {1'b1, 2'(i), diff[2:0]};
			end
		end
	endfunction

	// =====================================================
	// block register read at a data address
	// bit 8 flags a hit on a block register
	function automatic logic [8:0] reg_read(input logic [11:0] a);
		logic [11:0] low;
		reg_read = 9'h000;
		if (a == `BANK_ADDR) begin
			reg_read = {1'b1, 4'h0, bank_select_r};
		end
		if (a == `STATUS_ADDR) begin
			reg_read = {1'b1, 3'b000, status_flags};
		end
		if (a == `WORK_ADDR) begin
			reg_read = {1'b1, working_register};
		end
		for (int i = 0; i < `PTR_COUNT; i++) begin
			low = `PTR_LOW_BASE - 12'(`PTR_STRIDE * i);
			if (a == low) begin
				reg_read = {1'b1, ptr_val[i][7:0]};
			end
			if (a == low + 12'h001) begin
				reg_read = {1'b1, 4'h0, ptr_val[i][11:8]};
			end
		end
	endfunction

	// =====================================================
	// handshakes
	assign take = req_valid && req_ready;
	// core wins the cycle; the bus just waits one more
	assign bus_go = (avs_read || avs_write) && avs_waitrequest && !take;
	assign bus_wr = bus_go && avs_write && avs_byteenable[0];

	// =====================================================
	// address resolution
	always_comb begin
		// direct operand address
		if (req_move_file_to_file) begin
			eff_addr = req_full_addr;
		end else if (!req_access) begin
			if (req_file < `ACCESS_SPLIT) begin
				eff_addr = {`ACCESS_LOW_BANK, req_file};
			end else begin
				eff_addr = {`ACCESS_HIGH_BANK, req_file};
			end
		end else begin
			eff_addr = {bank_select_r, req_file};
		end
		od = oper_decode(eff_addr);
		is_ind = od[5];
		mode = ptr_mode_t'(od[2:0]);
		ptr_sel = ptr_val[od[4:3]];
		// indirect target by mode
		case (mode)
			MODE_PLUS_WORK: begin
				tgt = ptr_sel + {{4{working_register[7]}}, working_register};
			end
			MODE_PRE_INC: begin
				tgt = ptr_sel + 12'h001;
			end
			default: begin
				tgt = ptr_sel;
			end
		endcase
		if (!is_ind) begin
			tgt = eff_addr;
		end
		// classify the target
		reg_hit = reg_read(tgt);
		if (is_ind && oper_decode(tgt) >= 6'h20) begin // hit bit set
			kind = TK_NULL;
		end else if (reg_hit[8]) begin
			kind = TK_REG;
		end else if (((`IMPL_BANKS >> tgt[11:8]) & 16'h0001) == 16'h0000) begin
			kind = TK_VOID;
		end else begin
			kind = TK_RAM;
		end
	end

	// =====================================================
	// pointer control
	// stepping only follows operand mode, flags untouched
	always_comb begin
		core_reg_wr = take && req_write && (kind == TK_REG);
		load_data = take ? req_wdata : avs_writedata[7:0];
		for (int i = 0; i < `PTR_COUNT; i++) begin
			load_low[i] = (core_reg_wr && tgt == `PTR_LOW_BASE - 12'(`PTR_STRIDE * i))
				|| (bus_wr && avs_address == `BUS_PTR_BASE + 6'(8 * i));
			load_high[i] = (core_reg_wr
				&& tgt == `PTR_LOW_BASE - 12'(`PTR_STRIDE * i) + 12'h001)
				|| (bus_wr && avs_address == `BUS_PTR_BASE + 6'(8 * i + 4));
			step_up[i] = take && is_ind && (od[4:3] == 2'(i))
				&& (mode == MODE_POST_INC || mode == MODE_PRE_INC);
			step_down[i] = take && is_ind && (od[4:3] == 2'(i))
				&& (mode == MODE_POST_DEC);
		end
	end

	// =====================================================
	// three pointers
	genvar gi;
	generate
		for (gi = 0; gi < `PTR_COUNT; gi++) begin : g_ptr
			file_pointer_unit u_ptr (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.load_low(load_low[gi]),
				.load_high(load_high[gi]),
				.load_data(load_data),
				.step_up(step_up[gi]),
				.step_down(step_down[gi]),
				.ptr(ptr_val[gi])
			);
		end
	endgenerate

	// =====================================================
	// bank select
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			bank_select_r <= `RESET_BANK;
		end else if (core_reg_wr && tgt == `BANK_ADDR) begin
			bank_select_r <= req_wdata[3:0];
		end else if (bus_wr && avs_address == `BUS_BANK) begin
			bank_select_r <= avs_writedata[3:0];
		end
	end

	// =====================================================
	// working register
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			working_register <= `RESET_WORK;
		end else if (core_reg_wr && tgt == `WORK_ADDR) begin
			working_register <= req_wdata;
		end else if (bus_wr && avs_address == `BUS_WORK) begin
			working_register <= avs_writedata[7:0];
		end
	end

	// =====================================================
	// status flags, left unreset on purpose
	// the alu hands carries as carry-out of adding the
	// complement, so a set carry means no borrow
	always_ff @(posedge sys_clk) begin
		if (take && !(kind == TK_NULL && req_write)) begin
			for (int i = 0; i < `FLAG_BITS; i++) begin
				if (req_flag_mask[i]) begin
					status_flags[i] <= req_flag_val[i];
				end else if (core_reg_wr && tgt == `STATUS_ADDR) begin
					status_flags[i] <= req_wdata[i];
				end
			end
			if (kind == TK_NULL) begin
				status_flags[`FLAG_Z] <= 1'b1;
			end
		end else if (bus_wr && avs_address == `BUS_STATUS) begin
			status_flags <= avs_writedata[4:0];
		end
	end

	// =====================================================
	// access sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE, ST_DONE: begin
					state_r <= take ? ST_MEM : ST_IDLE;
				end
				ST_MEM: begin
					state_r <= ST_DATA;
				end
				ST_DATA: begin
					state_r <= ST_DONE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// =====================================================
	// request ready: low from take to response
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			req_ready <= 1'b1;
		end else if (take) begin
			req_ready <= 1'b0;
		end else if (state_r == ST_DATA) begin
			req_ready <= 1'b1;
		end
	end

	// =====================================================
	// ram strobes, one cycle after take
	// absent or null targets never reach the ram
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ram_addr <= 12'h000;
			ram_re <= 1'b0;
			ram_we <= 1'b0;
			ram_wdata <= 8'h00;
		end else if (take) begin
			ram_addr <= tgt;
			ram_re <= (kind == TK_RAM) && !req_write;
			ram_we <= (kind == TK_RAM) && req_write;
			ram_wdata <= req_wdata;
		end else begin
			ram_re <= 1'b0;
			ram_we <= 1'b0;
		end
	end

	// =====================================================
	// target bookkeeping
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			kind_r <= TK_RAM;
			hold_r <= 8'h00;
			last_tgt_r <= 12'h000;
		end else if (take) begin
			kind_r <= kind;
			last_tgt_r <= tgt;
			if (kind == TK_REG) begin
				hold_r <= reg_hit[7:0];
			end else begin
				hold_r <= `NULL_READ;
			end
		end
	end

	// =====================================================
	// response, three cycles after take
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else if (state_r == ST_DATA) begin
			rsp_valid <= 1'b1;
			rsp_data <= (kind_r == TK_RAM) ? ram_rdata : hold_r;
		end else begin
			rsp_valid <= 1'b0;
		end
	end

	// =====================================================
	// bus read decode
	always_comb begin
		case (avs_address)
			`BUS_BANK: bus_rd = {4'h0, bank_select_r};
			`BUS_STATUS: bus_rd = {3'b000, status_flags};
			`BUS_WORK: bus_rd = working_register;
			6'h0C: bus_rd = ptr_val[0][7:0];
			6'h10: bus_rd = {4'h0, ptr_val[0][11:8]};
			6'h14: bus_rd = ptr_val[1][7:0];
			6'h18: bus_rd = {4'h0, ptr_val[1][11:8]};
			6'h1C: bus_rd = ptr_val[2][7:0];
			6'h20: bus_rd = {4'h0, ptr_val[2][11:8]};
			`BUS_LAST: bus_rd = last_tgt_r[7:0];
			default: bus_rd = 8'h00;
		endcase
	end

	// =====================================================
	// avalon answer, one cycle of wait minimum
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (bus_go) begin
			avs_waitrequest <= 1'b0;
			if (avs_address == `BUS_LAST) begin
				avs_readdata <= {20'h00000, last_tgt_r};
			end else begin
				avs_readdata <= {24'h000000, bus_rd};
			end
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end
endmodule // data_memory_address_unit
`default_nettype wire

// *** bench/ram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// data ram partner, one-cycle read
module ram_model (
	// clock
	input wire logic sys_clk,
	// ram port
	input wire logic [11:0] ram_addr,
	input wire logic ram_re,
	input wire logic ram_we,
	input wire logic [7:0] ram_wdata,
	output logic [7:0] ram_rdata
);
	logic [7:0] mem [0:4095]; // whole data space
	// write at strobe edge, read answer one cycle on
	always_ff @(posedge sys_clk) begin
		if (ram_we) begin
			mem[ram_addr] <= ram_wdata;
		end
		// outside the answer cycle the bus flips, so stale data never passes
		if (ram_re) begin
			ram_rdata <= mem[ram_addr];
		end else begin
			ram_rdata <= ~ram_rdata;
		end
	end
endmodule // ram_model
`default_nettype wire

// *** bench/dmau_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module dmau_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// core side
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_move_file_to_file,
	input wire logic req_access,
	input wire logic [7:0] req_file,
	input wire logic [11:0] req_full_addr,
	input wire logic [7:0] req_wdata,
	input wire logic [4:0] req_flag_mask,
	input wire logic [4:0] req_flag_val,
	input wire logic rsp_valid,
	input wire logic [4:0] status_flags,
	// ram side
	input wire logic [11:0] ram_addr,
	input wire logic ram_re,
	input wire logic ram_we,
	input wire logic [7:0] ram_wdata,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire take = req_valid && req_ready; // request taken
	// direct access into the low access area
	wire low_hit = take && !req_move_file_to_file && !req_access && !req_file[7];
	wire req_write_seen = ram_we; // a ram write went out
	a_rsp_three: assert property (take |-> ##3 rsp_valid)
		else $error("response not three cycles after take");
	a_ready_gap: assert property (take |=> !req_ready ##1 !req_ready ##1 req_ready)
		else $error("ready gap wrong");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	a_strobe_src: assert property ((ram_re || ram_we) |-> $past(take))
		else $error("ram strobe without take");
	a_low_area: assert property (low_hit |=>
		(ram_re || ram_we) && ram_addr == {4'h0, $past(req_file)})
		else $error("low access area address wrong");
	a_move_full: assert property (take && req_move_file_to_file && req_full_addr[11:8] < 4'h6
		|=> (ram_re || ram_we) && ram_addr == $past(req_full_addr))
		else $error("full address not used");
	a_wdata_pass: assert property (ram_we |-> ram_wdata == $past(req_wdata))
		else $error("ram write data wrong");
	a_flag_take: assert property (low_hit |=>
		((status_flags ^ $past(req_flag_val)) & $past(req_flag_mask)) == 5'h00)
		else $error("masked flags not taken");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && !take
		|=> !avs_waitrequest)
		else $error("bus request not answered");
	c_write: cover property (req_write_seen);
	c_low: cover property (low_hit);
	c_bus_read: cover property (!avs_waitrequest && avs_read);
endmodule // dmau_properties
bind data_memory_address_unit dmau_properties chk (.sys_clk, .rst_b, .req_valid, .req_ready,
	.req_move_file_to_file, .req_access, .req_file, .req_full_addr, .req_wdata,
	.req_flag_mask, .req_flag_val, .rsp_valid, .status_flags, .ram_addr, .ram_re,
	.ram_we, .ram_wdata, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// self-checking bench
module tb_top;
	logic sys_clk = 1'b0, rst_b = 1'b0;
	logic req_valid = 0, req_move_file_to_file = 0, req_access = 0, req_write = 0;
	logic [7:0] req_file = 0, req_wdata = 0, rsp_data, ram_rdata, ram_wdata, working_register;
	logic [11:0] req_full_addr = 0, ram_addr, p, a;
	logic [4:0] req_flag_mask = 0, req_flag_val = 0, status_flags, v;
	logic req_ready, rsp_valid, ram_re, ram_we, avs_waitrequest;
	logic [5:0] avs_address = 0;
	logic avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hF, b;
	logic [7:0] f, d, w;
	int err_total = 0, n_tests = 0, i, seed = 46771;
	always #25 sys_clk = ~sys_clk; // 20 MHz
	data_memory_address_unit uut (.sys_clk, .rst_b, .req_valid, .req_move_file_to_file,
		.req_access, .req_file, .req_full_addr, .req_write, .req_wdata, .req_flag_mask,
		.req_flag_val, .req_ready, .rsp_valid, .rsp_data, .ram_addr, .ram_re, .ram_we,
		.ram_wdata, .ram_rdata, .status_flags, .working_register, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest);
	ram_model ram (.sys_clk, .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata);
	// ==========
	// helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	// avalon cycle, held until waitrequest sampled low
	task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] dt);
		@(posedge sys_clk);
		avs_address <= ad;
		avs_writedata <= dt;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// core request, held until taken, then wait for response
	task automatic op(input logic mf, ac, input logic [7:0] fl, input logic [11:0] fa,
		input logic wr, input logic [7:0] wd, input logic [4:0] m, vl);
		@(posedge sys_clk);
		{req_move_file_to_file, req_access, req_file, req_full_addr} <= {mf, ac, fl, fa};
		{req_write, req_wdata, req_flag_mask, req_flag_val} <= {wr, wd, m, vl};
		req_valid <= 1'b1;
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge sys_clk); while (rsp_valid !== 1'b1);
		q = rsp_data;
	endtask
	task automatic set_ptr(input logic [11:0] pv);
		bus(1, 6'h0C, pv[7:0]);
		bus(1, 6'h10, pv[11:8]);
	endtask
	task automatic chk_ptr(input logic [11:0] pv);
		bus(0, 6'h0C, 0);
		chk(q, pv[7:0]);
		bus(0, 6'h10, 0);
		chk(q, pv[11:8]);
	endtask
	// expected address and pointer after one operand access
	function automatic void step(input int k, input logic [7:0] wv,
		inout logic [11:0] pv, output logic [11:0] av);
		case (k)
			0: av = pv + {{4{wv[7]}}, wv};
			1: begin
				pv = pv + 12'h001;
				av = pv;
			end
			2: begin
				av = pv;
				pv = pv + 12'h001;
			end
			3: begin
				av = pv;
				pv = pv - 12'h001;
			end
			default: av = pv;
		endcase
	endfunction
	task automatic end_sim;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end
	// ==========
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		bus(0, 6'h00, 0);
		chk(q, 0);
		bus(0, 6'h08, 0);
		chk(q, 0);
		chk_ptr(12'h000);
		bus(0, 6'h28, 0);
		chk(q, 0);
		bus(1, 6'h00, 32'hFF);
		avs_byteenable <= 4'hE;
		bus(1, 6'h00, 32'h03);
		avs_byteenable <= 4'hF;
		bus(0, 6'h00, 0);
		chk(q, 32'h0F);
		// direct banks, bank 6 absent
		for (i = 0; i < 7; i++) begin
			b = i;
			f = $random(seed);
			d = $random(seed);
			v = $random(seed);
			bus(1, 6'h00, b);
			op(0, 1, f, 0, 1, d, 5'h1F, v);
			chk(status_flags, v);
			bus(0, 6'h24, 0);
			chk(q, {b, f});
			op(1, 0, 0, {b, f}, 0, 0, 0, 0);
			chk(q, (i < 6) ? d : 8'h00);
		end
		f = $random(seed) & 8'h7F;
		op(0, 0, f, 0, 1, d, $random(seed), $random(seed));
		op(1, 0, 0, {4'h0, f}, 0, 0, 0, 0);
		chk(q, d);
		op(0, 0, 8'hE8, 0, 1, d, 0, 0);
		bus(0, 6'h08, 0);
		chk(q, d);
		chk(working_register, d);
		op(0, 0, 8'hD8, 0, 1, 8'hFF, 5'h1F, 5'h0A);
		chk(status_flags, 5'h0A);
		op(0, 0, 8'hD8, 0, 1, 8'hFF, 0, 0);
		bus(0, 6'h04, 0);
		chk(q, 32'h1F);
		// clear all flags so a pointer reaching zero would show in Z
		op(0, 0, 8'hD8, 0, 1, 8'h00, 0, 0);
		// operand modes from boundary and random pointers
		for (i = 0; i < 15; i++) begin
			if (i % 5 == 0) begin
				p = (i == 0) ? 12'h0FF : (i == 5) ? 12'hFFF : {4'h1, 8'($random(seed))};
				w = (i == 0) ? 8'h80 : (i == 5) ? 8'h01 : $random(seed);
				op(0, 0, 8'hE8, 0, 1, w, 0, 0);
				set_ptr(p);
			end
			step(i % 5, w, p, a);
			op(0, 0, 8'hEB + i % 5, 0, 1, $random(seed), 0, 0);
			bus(0, 6'h24, 0);
			chk(q, a);
			chk_ptr(p);
			chk(status_flags, 5'h00);
		end
		// pointer aimed at its own operand location
		op(0, 0, 8'hD8, 0, 1, 0, 5'h1F, 5'h00);
		set_ptr(12'hFEB);
		op(0, 0, 8'hEF, 0, 0, 0, 0, 0);
		chk(q, 0);
		chk(status_flags, 5'h04);
		op(0, 0, 8'hEF, 0, 1, 8'h5A, 5'h1F, 5'h1F);
		chk(status_flags, 5'h04);
		// write to the pointer's own low byte beats post-increment
		set_ptr(12'hFE9);
		op(0, 0, 8'hED, 0, 1, 8'h55, 0, 0);
		chk_ptr(12'hF55);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
